// ---- hw/pbc_burst_cfg.sv ----
`timescale 1ns/1ps
`include "pbc_consts.svh"
// Function
// - wrap bit zero keeps fixed bursts inside their length boundary; one goes linear
// - without wrap, addresses increase linearly across the boundary and on past row end
// - burst lengths 4, 8, 16, 32 and continuous from low three bits
// - drive field: 00 full, 01 half, 10 quarter, 11 reserved
// - wait output flags invalid output data during synchronous burst reads
// - wait asserted for initial delay, row end and refresh collision
// - row crossing asserts wait from last word of old row; rows 256 words
// - polarity bit one drives wait high when asserted, zero drives low
// - timing bit zero: wait changes on the same edge as the data it flags
// - timing bit one: wait changes one clock before data changes
// - outside synchronous bursts wait sits at the asserted level
// - after power-up outputs use half drive strength until rewritten
module pbc_burst_cfg #(
  parameter int ADDR_W = 22
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                cfg_we_i,
  input  wire logic [15:0]         cfg_wdata_i,
  output logic      [15:0]         cfg_rdata_o,
  input  wire logic                burst_start_i,
  input  wire logic [ADDR_W-1:0]   burst_addr_i,
  input  wire logic                burst_stop_i,
  input  wire logic                host_ready_i,
  output logic                     arr_req_o,
  output logic      [ADDR_W-1:0]   arr_addr_o,
  input  wire logic                arr_valid_i,
  input  wire logic [15:0]         arr_data_i,
  output logic      [15:0]         dq_o,
  output logic                     dq_valid_o,
  output logic                     wait_o,
  output pbc_pkg::pbc_drive_t      drive_o
);
  import pbc_pkg::*;

  if (ADDR_W < `PBC_ROW_BITS + 1) begin : g_addr_w_check
    $error("ADDR_W too small for row addressing");
  end

  localparam logic [1:0] GAP_CYC = 2'(`PBC_ROW_GAP_CYC);

  // =====================================================================
  // reset release
  logic rst_meta;
  logic rst_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_q    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_q    <= rst_meta;
    end
  end

  // =====================================================================
  // helpers
  function automatic logic [5:0] len_words(input logic [2:0] code);
    case (code)
      `PBC_LEN_4:  len_words = 6'h04;
      `PBC_LEN_8:  len_words = 6'h08;
      `PBC_LEN_16: len_words = 6'h10;
      `PBC_LEN_32: len_words = 6'h20;
      default:     len_words = 6'h00;
    endcase
  endfunction

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [2:0] code,
                                                  input logic linear);
    logic [ADDR_W-1:0] mask;
    logic [ADDR_W-1:0] inc;
    mask = ADDR_W'(len_words(code)) - ADDR_W'(1);
    inc  = a + ADDR_W'(1);
    if (!linear && len_words(code) != 6'h00) begin
      step_addr = (a & ~mask) | (inc & mask);
    end else begin
      step_addr = inc;
    end
  endfunction

  // =====================================================================
  // configuration word
  logic [15:0] cfg;
  logic [15:0] next_cfg;
  logic        sync_act;

  always_comb begin
    next_cfg = cfg;
    if (cfg_we_i && !sync_act) begin
      next_cfg = cfg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      cfg <= `PBC_CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  logic [2:0] len_code;
  logic       linear;
  logic       wtim;
  logic       wpol;
  logic [5:0] len_n;
  assign len_code    = cfg[`PBC_LEN_MSB:`PBC_LEN_LSB];
  assign linear      = cfg[`PBC_WRAP_BIT];
  assign wtim        = cfg[`PBC_WTIM_BIT];
  assign wpol        = cfg[`PBC_WPOL_BIT];
  assign len_n       = len_words(len_code);
  assign cfg_rdata_o = cfg;
  assign drive_o     = pbc_drive_t'(cfg[`PBC_DRV_MSB:`PBC_DRV_LSB]);

  // =====================================================================
  // two-entry output buffer
  pbc_word_t buf_mem [2];
  pbc_word_t next_mem0;
  pbc_word_t next_mem1;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       buf_push;
  logic       buf_pop;
  logic       buf_full;
  logic       buf_empty;
  pbc_word_t  buf_in;

  assign buf_full  = (cnt == 2'd2);
  assign buf_empty = (cnt == 2'd0);
  assign buf_pop   = !buf_empty && host_ready_i;

  always_comb begin
    next_mem0 = buf_mem[0];
    next_mem1 = buf_mem[1];
    next_cnt  = cnt;
    if (burst_start_i || burst_stop_i) begin
      next_cnt = 2'd0;
    end else begin
      if (buf_pop) begin
        next_mem0 = buf_mem[1];
      end
      if (buf_push) begin
        if (cnt == 2'd0 || (cnt == 2'd1 && buf_pop)) begin
          next_mem0 = buf_in;
        end else begin
          next_mem1 = buf_in;
        end
      end
      next_cnt = 2'(cnt + 2'(buf_push) - 2'(buf_pop));
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      cnt        <= 2'd0;
    end else begin
      buf_mem[0] <= next_mem0;
      buf_mem[1] <= next_mem1;
      cnt        <= next_cnt;
    end
  end

  // =====================================================================
  // fetch sequencer
  pbc_state_t        state;
  pbc_state_t        next_state;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [5:0]        done_n;
  logic [5:0]        next_done_n;
  logic [1:0]        gap;
  logic [1:0]        next_gap;
  logic              next_sync_act;
  logic              row_last;
  logic              last_of_len;

  assign arr_req_o   = (state == PBC_ST_FETCH) && !buf_full;
  assign arr_addr_o  = addr;
  assign buf_push    = arr_req_o && arr_valid_i && !burst_start_i;
  assign row_last    = (addr[`PBC_ROW_BITS-1:0] == {`PBC_ROW_BITS{1'b1}});
  assign last_of_len = (len_n != 6'h00) && (done_n == len_n - 6'h01);
  // old row's last word carries the end-of-row mark
  assign buf_in.data = arr_data_i;
  assign buf_in.eor  = row_last && (linear || len_n == 6'h00) && !last_of_len;

  always_comb begin
    next_state    = state;
    next_addr     = addr;
    next_done_n   = done_n;
    next_gap      = gap;
    next_sync_act = sync_act;
    if (burst_start_i) begin
      next_state    = PBC_ST_FETCH;
      next_addr     = burst_addr_i;
      next_done_n   = 6'h00;
      next_sync_act = 1'b1;
    end else if (burst_stop_i) begin
      next_state    = PBC_ST_IDLE;
      next_sync_act = 1'b0;
    end else begin
      unique case (state)
        PBC_ST_IDLE: begin
          next_state = PBC_ST_IDLE;
        end
        PBC_ST_FETCH: begin
          if (buf_push) begin
            next_addr   = step_addr(addr, len_code, linear);
            next_done_n = done_n + 6'h01;
            if (last_of_len) begin
              next_state = PBC_ST_DONE;
            end else if (buf_in.eor) begin
              next_state = PBC_ST_GAP;
              next_gap   = GAP_CYC;
            end
          end
        end
        PBC_ST_GAP: begin
          next_gap = gap - 2'd1;
          if (gap == 2'd1) begin
            next_state = PBC_ST_FETCH;
          end
        end
        PBC_ST_DONE: begin
          next_state = PBC_ST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      state    <= PBC_ST_IDLE;
      addr     <= '0;
      done_n   <= 6'h00;
      gap      <= 2'd0;
      sync_act <= 1'b0;
    end else begin
      state    <= next_state;
      addr     <= next_addr;
      done_n   <= next_done_n;
      gap      <= next_gap;
      sync_act <= next_sync_act;
    end
  end

  // =====================================================================
  // data bus and wait
  logic [15:0] next_dq;
  logic        next_dq_valid;
  logic        dq_eor;
  logic        next_dq_eor;
  logic        wait_act;
  logic        burst_more;

  always_comb begin
    next_dq       = dq_o;
    next_dq_valid = buf_pop && !burst_start_i && !burst_stop_i;
    next_dq_eor   = 1'b0;
    if (next_dq_valid) begin
      next_dq     = buf_mem[0].data;
      next_dq_eor = buf_mem[0].eor;
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      dq_o       <= 16'h0000;
      dq_valid_o <= 1'b0;
      dq_eor     <= 1'b0;
    end else begin
      dq_o       <= next_dq;
      dq_valid_o <= next_dq_valid;
      dq_eor     <= next_dq_eor;
    end
  end

  assign burst_more = (state != PBC_ST_DONE) || !buf_empty;

  always_comb begin
    if (!sync_act) begin
      wait_act = 1'b1;
    end else if (wtim) begin
      // look ahead at the word that goes out next edge
      wait_act = !next_dq_valid || (next_dq_eor && burst_more);
    end else begin
      wait_act = !dq_valid_o || (dq_eor && burst_more);
    end
  end

  assign wait_o = wait_act ? wpol : !wpol;

  // =====================================================================
  // checks
  AST_ASYNC_WAIT: assert property (@(posedge clk_i) disable iff (!rst_q)
    !sync_act |-> wait_o == wpol)
    else $error("wait not at asserted level outside burst");

  AST_DRIVE_DEC: assert property (@(posedge clk_i) disable iff (!rst_q)
    cfg[5:4] == 2'b10 |-> drive_o == PBC_DRV_QUARTER)
    else $error("drive field decoded wrongly");

  AST_RESET_HALF: assert property (@(posedge clk_i)
    rst_q && !$past(rst_q) |-> drive_o == PBC_DRV_HALF && wtim && wpol)
    else $error("configuration not at power-up default");

  AST_WRAP_UPPER: assert property (@(posedge clk_i) disable iff (!rst_q)
    buf_push && !linear && len_code == `PBC_LEN_8 && !burst_stop_i
    |=> addr[ADDR_W-1:3] == $past(addr[ADDR_W-1:3]))
    else $error("wrap burst left its length boundary");

  AST_LINEAR_STEP: assert property (@(posedge clk_i) disable iff (!rst_q)
    buf_push && linear && !burst_stop_i |=> addr == $past(addr) + ADDR_W'(1))
    else $error("linear burst did not step by one");

  AST_LEN_LIMIT: assert property (@(posedge clk_i) disable iff (!rst_q)
    buf_push && len_n != 6'h00 |-> done_n < len_n)
    else $error("burst fetched more words than its length");

  AST_WAIT_T0: assert property (@(posedge clk_i) disable iff (!rst_q)
    sync_act && !wtim && !dq_valid_o |-> wait_o == wpol)
    else $error("wait not asserted with invalid data");

  AST_WAIT_T1: assert property (@(posedge clk_i) disable iff (!rst_q)
    sync_act && wtim && wait_o != wpol && !burst_start_i |=> dq_valid_o)
    else $error("data not valid one clock after wait released");

  AST_ROW_END: assert property (@(posedge clk_i) disable iff (!rst_q)
    sync_act && !wtim && dq_valid_o && dq_eor && state == PBC_ST_GAP |-> wait_o == wpol)
    else $error("wait not asserted on last word of row");

endmodule

// ---- hw/pbc_consts.svh ----
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// =====================================================================
// configuration word layout
`define PBC_CFG_RESET      16'h9D1F
`define PBC_LEN_LSB        0
`define PBC_LEN_MSB        2
`define PBC_WRAP_BIT       3
`define PBC_DRV_LSB        4
`define PBC_DRV_MSB        5
`define PBC_WTIM_BIT       8
`define PBC_WPOL_BIT       10

// =====================================================================
// burst length codes
`define PBC_LEN_4          3'h1
`define PBC_LEN_8          3'h2
`define PBC_LEN_16         3'h3
`define PBC_LEN_32         3'h4
`define PBC_LEN_CONT       3'h7

// =====================================================================
// row geometry and row-crossing delay
`define PBC_ROW_BITS       8
`define PBC_CLK_PERIOD_NS  20
`define PBC_ROW_GAP_NS     40
`define PBC_ROW_GAP_CYC    ((`PBC_ROW_GAP_NS + `PBC_CLK_PERIOD_NS - 1) / `PBC_CLK_PERIOD_NS)

`endif

// ---- hw/pbc_pkg.sv ----
package pbc_pkg;

  typedef enum logic [1:0] {
    PBC_DRV_FULL    = 2'b00,
    PBC_DRV_HALF    = 2'b01,
    PBC_DRV_QUARTER = 2'b10,
    PBC_DRV_RSVD    = 2'b11
  } pbc_drive_t;

  typedef enum logic [1:0] {
    PBC_ST_IDLE  = 2'b00,
    PBC_ST_FETCH = 2'b01,
    PBC_ST_GAP   = 2'b10,
    PBC_ST_DONE  = 2'b11
  } pbc_state_t;

  typedef struct packed {
    logic [15:0] data;
    logic        eor;
  } pbc_word_t;

endpackage

// ---- sim/pbc_host_model.sv ----
`timescale 1ns/1ps
// =====================================================================
// host side: paces reads, collects flagged words
module pbc_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        dq_valid_i,
  input  wire logic        stall_i,
  output logic             host_ready_o
);
  logic [15:0] got[$];
  logic [1:0]  phase;

  initial begin
    host_ready_o = 1'b1;
    phase        = 2'h0;
  end

  // one stall in three when asked; wait never steers the host
  always @(negedge clk_i) begin
    phase        <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    host_ready_o <= !(stall_i && phase == 2'h2);
  end

  // words taken only in cycles flagged valid
  always @(posedge clk_i) begin
    if (dq_valid_i) begin
      got.push_back(dq_i);
    end
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`include "pbc_consts.svh"
module tb;
  import pbc_pkg::*;
  logic        clk_i, rst_n_i, cfg_we_i, burst_start_i, burst_stop_i, arr_valid_i;
  logic        host_ready_i, arr_req_o, dq_valid_o, wait_o;
  logic        stall, gaps, mon_en, pol, tim, prev_wait, exp_wait;
  logic [15:0] cfg_wdata_i, cfg_rdata_o, arr_data_i, dq_o;
  logic [21:0] burst_addr_i, arr_addr_o;
  pbc_drive_t  drive_o;
  int          err_total, tests_run, k;

  always #10 clk_i = ~clk_i;
  // array word mirrors its address; gaps stand for refresh collisions
  assign arr_data_i = arr_addr_o[15:0];
  always @(negedge clk_i) arr_valid_i <= gaps ? ~arr_valid_i : 1'b1;

  pbc_burst_cfg u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_we_i(cfg_we_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .burst_start_i(burst_start_i), .burst_addr_i(burst_addr_i),
    .burst_stop_i(burst_stop_i), .host_ready_i(host_ready_i), .arr_req_o(arr_req_o),
    .arr_addr_o(arr_addr_o), .arr_valid_i(arr_valid_i), .arr_data_i(arr_data_i),
    .dq_o(dq_o), .dq_valid_o(dq_valid_o), .wait_o(wait_o), .drive_o(drive_o)
  );

  pbc_host_model u_host (
    .clk_i(clk_i), .dq_i(dq_o), .dq_valid_i(dq_valid_o), .stall_i(stall),
    .host_ready_o(host_ready_i)
  );

  // =====================================================================
  // tasks
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] cw(input logic [2:0] c, input logic lin, t, p);
    return {4'h9, 1'b1, p, 1'b0, t, 4'h1, lin, c};
  endfunction

  task automatic cfg_wr(input logic [15:0] v);
    @(negedge clk_i);
    cfg_we_i    = 1'b1;
    cfg_wdata_i = v;
    @(negedge clk_i);
    cfg_we_i    = 1'b0;
  endtask

  task automatic burst(input logic [15:0] c, input logic [21:0] a, input int n, input int len);
    logic [21:0] e;
    logic [21:0] m;
    int          w;
    cfg_wr(c);
    pol    = c[10];
    tim    = c[8];
    u_host.got.delete();
    burst_addr_i  = a;
    burst_start_i = 1'b1;
    @(negedge clk_i);
    burst_start_i = 1'b0;
    mon_en        = 1'b1;
    cfg_wr(16'h0000);
    chk(cfg_rdata_o, c);
    w = 0;
    while (u_host.got.size() < n && w < 300) begin
      @(negedge clk_i);
      w++;
    end
    if (len > 0) begin
      repeat (10) @(negedge clk_i);
      chk(22'(u_host.got.size()), 22'(n));
      chk(22'(arr_req_o), 22'h000000);
    end else begin
      chk(22'(u_host.got.size() >= n), 22'h000001);
    end
    m = 22'(len - 1);
    for (int i = 0; i < n && i < u_host.got.size(); i++) begin
      e = (c[3] || len == 0) ? a + 22'(i) : (a & ~m) | ((a + 22'(i)) & m);
      chk(u_host.got[i], e[15:0]);
    end
    mon_en = 1'b0;
    burst_stop_i = 1'b1;
    @(negedge clk_i);
    burst_stop_i = 1'b0;
    @(negedge clk_i);
  endtask

  // =====================================================================
  // wait monitor, taken at the rising edge where wait has settled
  always @(posedge clk_i) begin
    exp_wait = (!dq_valid_o || dq_o[7:0] == 8'hFF) ? pol : !pol;
    if (mon_en && !tim) begin
      chk(wait_o, exp_wait);
    end
    if (mon_en && tim) begin
      chk(prev_wait, exp_wait);
    end
    prev_wait = wait_o;
  end

  // =====================================================================
  // main sequence
  initial begin
    clk_i         = 1'b0;
    rst_n_i       = 1'b0;
    cfg_we_i      = 1'b0;
    cfg_wdata_i   = 16'h0000;
    burst_start_i = 1'b0;
    burst_stop_i  = 1'b0;
    burst_addr_i  = 22'h000000;
    {stall, gaps, mon_en} = 3'h0;
    {pol, tim, prev_wait} = 3'h7;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(cfg_rdata_o, `PBC_CFG_RESET);
    chk(drive_o, PBC_DRV_HALF);
    chk(wait_o, 1'b1);
    for (k = 0; k < 4; k++) begin
      cfg_wr({10'h274, 2'(k), 4'hF});
      chk(drive_o, 22'(k));
    end
    cfg_wr(cw(3'h7, 1'b1, 1'b0, 1'b0));
    chk(wait_o, 1'b0);
    for (k = 1; k <= 4; k++) begin
      burst(cw(3'(k), 1'b0, k[0], k[1]), 22'h100 + 22'((2 << k) - 3), 2 << k, 2 << k);
    end
    burst(cw(3'h1, 1'b1, 1'b1, 1'b1), 22'h000103, 4, 4);
    stall = 1'b1;
    gaps  = 1'b1;
    burst(cw(3'h7, 1'b1, 1'b0, 1'b1), 22'h0001FD, 6, 0);
    burst(cw(3'h7, 1'b0, 1'b1, 1'b0), 22'h0002FE, 4, 0);
    conclude();
  end

  // run needs a few hundred cycles; this span leaves wide margin
  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule
